/* File: vpe_pkg.sv */
// constants shared by the voltage protection block: register map, fields, timing
// assumes a 100 MHz system clock and 32-bit classic wishbone register access
package vpe_pkg;

  localparam int unsigned NUM_ELEM      = 6;
  localparam int unsigned VOLT_W        = 16;
  localparam int unsigned THR_W         = 12;
  localparam int unsigned DLY_W         = 16;
  localparam int unsigned CMP_W         = 28;
  localparam int unsigned ACC_W         = 46;

  // element order in every per-element array
  localparam int unsigned EL_PH_UNDER   = 0;
  localparam int unsigned EL_PH_OVER    = 1;
  localparam int unsigned EL_NEUT_OVER  = 2;
  localparam int unsigned EL_NEG_OVER   = 3;
  localparam int unsigned EL_AUX_UNDER  = 4;
  localparam int unsigned EL_AUX_OVER   = 5;

  // clock and delay step
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned STEP_MS       = 10;
  localparam int unsigned STEP_CYCLES   = (CLK_HZ / 1000) * STEP_MS;

  // threshold unit is 0.001 per-unit, so per-unit base is 1000 steps
  localparam logic [9:0]  PU_STEPS      = 10'h3e8;
  localparam logic [THR_W-1:0] THR_MAX_STD = 12'hbb8;
  localparam logic [THR_W-1:0] THR_MAX_NEG = 12'h4e2;
  // 600.00 s in 0.01 s steps
  localparam logic [DLY_W-1:0] DLY_MAX  = 16'hea60;

  // global register byte offsets
  localparam logic [7:0] OFS_CONFIG     = 8'h00;
  localparam logic [7:0] OFS_PH_NOM     = 8'h04;
  localparam logic [7:0] OFS_AUX_NOM    = 8'h08;
  localparam logic [7:0] OFS_STATE      = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT   = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
  // element banks: base + index * stride
  localparam logic [7:0] OFS_ELEM_BASE  = 8'h40;
  localparam int unsigned ELEM_STRIDE_LG = 5;
  localparam logic [2:0] EOFS_CTRL      = 3'h0;
  localparam logic [2:0] EOFS_THR       = 3'h1;
  localparam logic [2:0] EOFS_OPD       = 3'h2;
  localparam logic [2:0] EOFS_RLD       = 3'h3;
  localparam logic [2:0] EOFS_MINV      = 3'h4;

  // config fields
  localparam int unsigned CFG_DELTA_BIT = 0;
  localparam int unsigned CFG_PP_BIT    = 1;
  // element control fields
  localparam int unsigned CTL_EN_BIT    = 0;
  localparam int unsigned CTL_INV_BIT   = 1;

  // reset values
  localparam logic [1:0]        CFG_RST   = 2'h0;
  localparam logic [VOLT_W-1:0] NOM_RST   = 16'h2ee0;
  localparam logic [1:0]        CTL_RST   = 2'h0;
  localparam logic [THR_W-1:0]  THR_RST   = 12'h3e8;
  localparam logic [DLY_W-1:0]  DLY_RST   = 16'h0064;
  localparam logic [VOLT_W-1:0] MINV_RST  = 16'h0000;

endpackage

/* File: vpe_timer.sv */
// pickup / operate / release timer shared by every voltage element
// assumes step_i is a one-cycle pulse every delay step, all inputs on clk_i
`timescale 1ns/1ps
module vpe_timer #(
  parameter int unsigned ACC_W = vpe_pkg::ACC_W,
  parameter int unsigned DLY_W = vpe_pkg::DLY_W
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             clear_i,
  input  wire logic             step_i,
  input  wire logic             cond_i,
  input  wire logic [ACC_W-1:0] weight_i,
  input  wire logic [ACC_W-1:0] target_i,
  input  wire logic [DLY_W-1:0] release_i,
  output logic                  pickup_o,
  output logic                  operate_o
);

  logic [ACC_W-1:0] acc_ff;
  logic [DLY_W-1:0] rel_cnt_ff;
  logic             op_ff;
  logic             pk_ff;
  logic             armed_ff;
  logic             counting;
  logic [ACC_W:0]   nxt_sum;

  assign nxt_sum = {1'b0, acc_ff} + {1'b0, weight_i};

  // a step that lands part way into a new state is dropped, so delays are never cut short
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      armed_ff <= 1'b0;
    else if (cond_i != pk_ff)
      armed_ff <= step_i;
    else if (step_i)
      armed_ff <= 1'b1;
  end

  assign counting = step_i && armed_ff && (cond_i == pk_ff);

  // integrate while picked up; saturate rather than wrap on long faults
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i || !cond_i)
      acc_ff <= '0;
    else if (counting && acc_ff < target_i)
      acc_ff <= nxt_sum[ACC_W] ? '1 : nxt_sum[ACC_W-1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i || cond_i || !op_ff)
      rel_cnt_ff <= '0;
    else if (counting && rel_cnt_ff < release_i)
      rel_cnt_ff <= rel_cnt_ff + 1'b1;
  end

  // operate after held delay, drop after release delay
  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      op_ff <= 1'b0;
    else if (cond_i && acc_ff >= target_i)
      op_ff <= 1'b1;
    else if (!cond_i && rel_cnt_ff >= release_i)
      op_ff <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || clear_i)
      pk_ff <= 1'b0;
    else
      pk_ff <= cond_i;
  end

  assign pickup_o  = pk_ff;
  assign operate_o = op_ff;

endmodule // vpe_timer

/* File: vpe_top.sv */
// voltage protection elements: six threshold/timer elements behind wishbone
// assumes voltage magnitudes arrive from measurement logic on clk_i, same units
// as the nominal secondary registers; inhibit inputs are also synchronous
`timescale 1ns/1ps
module vpe_top #(
  parameter int unsigned STEP_CYCLES = vpe_pkg::STEP_CYCLES
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  // classic wishbone slave
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [7:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic [31:0]                    wb_dat_o,
  output logic                           wb_ack_o,
  // measured magnitudes
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_an_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_bn_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_cn_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_ab_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_bc_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_ca_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_zero_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_neg_i,
  input  wire logic [vpe_pkg::VOLT_W-1:0] v_aux_i,
  // per-element inhibit, bit order as element index
  input  wire logic [vpe_pkg::NUM_ELEM-1:0] inhibit_i,
  output logic [vpe_pkg::NUM_ELEM-1:0]   pickup_o,
  output logic [vpe_pkg::NUM_ELEM-1:0]   operate_o,
  output logic                           irq_o
);

  localparam int unsigned NE = vpe_pkg::NUM_ELEM;
  localparam int unsigned VW = vpe_pkg::VOLT_W;
  localparam int unsigned TW = vpe_pkg::THR_W;
  localparam int unsigned DW = vpe_pkg::DLY_W;
  localparam int unsigned CW = vpe_pkg::CMP_W;
  localparam int unsigned AW = vpe_pkg::ACC_W;

  // voltage in threshold steps of the nominal: v * 1000
  function automatic logic [CW-1:0] vpe_vk(input logic [VW+1:0] v);
    vpe_vk = CW'(v) * CW'(vpe_pkg::PU_STEPS);
  endfunction

  function automatic logic [CW-1:0] vpe_scaled(input logic [TW-1:0] thr,
                                               input logic [VW-1:0] nom);
    vpe_scaled = CW'(thr) * CW'(nom);
  endfunction

  function automatic logic [VW-1:0] vpe_min3(input logic [VW-1:0] a,
                                             input logic [VW-1:0] b,
                                             input logic [VW-1:0] c);
    logic [VW-1:0] m;
    m = (a < b) ? a : b;
    vpe_min3 = (m < c) ? m : c;
  endfunction

  function automatic logic [VW-1:0] vpe_max3(input logic [VW-1:0] a,
                                             input logic [VW-1:0] b,
                                             input logic [VW-1:0] c);
    logic [VW-1:0] m;
    m = (a > b) ? a : b;
    vpe_max3 = (m > c) ? m : c;
  endfunction

  // ---------------- settings storage ----------------
  logic [1:0]    cfg_ff;
  logic [VW-1:0] ph_nom_ff;
  logic [VW-1:0] aux_nom_ff;
  logic [1:0]    ctl_ff  [NE];
  logic [TW-1:0] thr_ff  [NE];
  logic [DW-1:0] opd_ff  [NE];
  logic [DW-1:0] rld_ff  [NE];
  logic [VW-1:0] minv_ff [NE];
  logic [NE-1:0] irq_stat_ff;
  logic [NE-1:0] irq_mask_ff;
  logic          ack_ff;
  logic [31:0]   rdat_ff;

  logic          bus_req;
  logic          wr_go;
  logic          is_elem;
  logic [2:0]    e_idx;
  logic [2:0]    e_reg;
  logic          e_hit;

  assign bus_req = wb_cyc_i && wb_stb_i && !ack_ff;
  assign wr_go   = bus_req && wb_we_i;
  assign is_elem = wb_adr_i >= vpe_pkg::OFS_ELEM_BASE;
  assign e_idx   = 3'((wb_adr_i - vpe_pkg::OFS_ELEM_BASE) >> vpe_pkg::ELEM_STRIDE_LG);
  assign e_reg   = wb_adr_i[4:2];
  assign e_hit   = is_elem && (32'(e_idx) < NE) && (e_reg <= vpe_pkg::EOFS_MINV)
                   && (wb_adr_i[1:0] == 2'h0);

  // write data merged under byte enables
  function automatic logic [31:0] vpe_merge(input logic [31:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        r[8*b +: 8] = dat[8*b +: 8];
    vpe_merge = r;
  endfunction

  // one-cycle ack per request, unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cfg_ff     <= vpe_pkg::CFG_RST;
      ph_nom_ff  <= vpe_pkg::NOM_RST;
      aux_nom_ff <= vpe_pkg::NOM_RST;
    end
    else if (wr_go)
    begin
      case (wb_adr_i)
        vpe_pkg::OFS_CONFIG:
          cfg_ff <= 2'(vpe_merge(32'(cfg_ff), wb_dat_i, wb_sel_i));
        vpe_pkg::OFS_PH_NOM:
          ph_nom_ff <= VW'(vpe_merge(32'(ph_nom_ff), wb_dat_i, wb_sel_i));
        vpe_pkg::OFS_AUX_NOM:
          aux_nom_ff <= VW'(vpe_merge(32'(aux_nom_ff), wb_dat_i, wb_sel_i));
        default:
          cfg_ff <= cfg_ff;
      endcase
    end
  end

  logic [31:0] wthr;
  logic [31:0] wopd;
  logic [31:0] wrld;
  logic [TW-1:0] thr_lim;

  always_comb
  begin
    wthr    = vpe_merge(32'(thr_ff[e_idx]), wb_dat_i, wb_sel_i);
    wopd    = vpe_merge(32'(opd_ff[e_idx]), wb_dat_i, wb_sel_i);
    wrld    = vpe_merge(32'(rld_ff[e_idx]), wb_dat_i, wb_sel_i);
    thr_lim = (32'(e_idx) == vpe_pkg::EL_NEG_OVER) ? vpe_pkg::THR_MAX_NEG
                                                   : vpe_pkg::THR_MAX_STD;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < NE; i++)
      begin
        ctl_ff[i]  <= vpe_pkg::CTL_RST;
        thr_ff[i]  <= vpe_pkg::THR_RST;
        opd_ff[i]  <= vpe_pkg::DLY_RST;
        rld_ff[i]  <= vpe_pkg::DLY_RST;
        minv_ff[i] <= vpe_pkg::MINV_RST;
      end
    end
    else if (wr_go && e_hit)
    begin
      case (e_reg)
        vpe_pkg::EOFS_CTRL:
          ctl_ff[e_idx] <= 2'(vpe_merge(32'(ctl_ff[e_idx]), wb_dat_i, wb_sel_i));
        // threshold held in 0.001 pu steps, clamped to range
        vpe_pkg::EOFS_THR:
          thr_ff[e_idx] <= (wthr > 32'(thr_lim)) ? thr_lim : TW'(wthr);
        // delays in 0.01 s steps, clamped to 600.00 s
        vpe_pkg::EOFS_OPD:
          opd_ff[e_idx] <= (wopd > 32'(vpe_pkg::DLY_MAX)) ? vpe_pkg::DLY_MAX : DW'(wopd);
        vpe_pkg::EOFS_RLD:
          rld_ff[e_idx] <= (wrld > 32'(vpe_pkg::DLY_MAX)) ? vpe_pkg::DLY_MAX : DW'(wrld);
        vpe_pkg::EOFS_MINV:
          minv_ff[e_idx] <= VW'(vpe_merge(32'(minv_ff[e_idx]), wb_dat_i, wb_sel_i));
        default:
          minv_ff[e_idx] <= minv_ff[e_idx];
      endcase
    end
  end

  // ---------------- delay step divider ----------------
  logic [31:0] div_ff;
  logic        step_ff;

  // definite delay counted in 10 ms steps
  always_ff @(posedge clk_i)
  begin
    if (rst_i || div_ff == 32'(STEP_CYCLES - 1))
      div_ff <= '0;
    else
      div_ff <= div_ff + 32'h1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      step_ff <= 1'b0;
    else
      step_ff <= (div_ff == 32'(STEP_CYCLES - 1));
  end

  // ---------------- measurement selection ----------------
  logic          delta;
  logic [VW-1:0] ph_under_v;
  logic [VW-1:0] ph_over_v;
  logic [VW+1:0] neut_v;
  logic [VW+1:0] v_sel [NE];
  logic [VW-1:0] nom_sel [NE];
  logic [NE-1:0] is_under;
  logic [NE-1:0] cond;
  logic [NE-1:0] clear;
  logic [CW-1:0] thr_sc [NE];
  logic [CW-1:0] v_sc   [NE];
  logic [AW-1:0] weight [NE];
  logic [AW-1:0] target [NE];

  assign delta = cfg_ff[vpe_pkg::CFG_DELTA_BIT];

  // delta forces phase-to-phase; wye may pick either
  assign ph_under_v = (delta || cfg_ff[vpe_pkg::CFG_PP_BIT])
                      ? vpe_min3(v_ab_i, v_bc_i, v_ca_i)
                      : vpe_min3(v_an_i, v_bn_i, v_cn_i);
  // overvoltage on phase-to-phase, wye values computed upstream
  assign ph_over_v = vpe_max3(v_ab_i, v_bc_i, v_ca_i);
  // neutral quantity is three times zero-sequence
  assign neut_v = (VW+2)'(v_zero_i) * (VW+2)'(3);

  assign is_under = NE'(6'h11);

  always_comb
  begin
    v_sel[vpe_pkg::EL_PH_UNDER]    = (VW+2)'(ph_under_v);
    v_sel[vpe_pkg::EL_PH_OVER]     = (VW+2)'(ph_over_v);
    v_sel[vpe_pkg::EL_NEUT_OVER]   = neut_v;
    v_sel[vpe_pkg::EL_NEG_OVER]    = (VW+2)'(v_neg_i);
    // aux channel on aux nominal base
    v_sel[vpe_pkg::EL_AUX_UNDER]   = (VW+2)'(v_aux_i);
    v_sel[vpe_pkg::EL_AUX_OVER]    = (VW+2)'(v_aux_i);
    nom_sel[vpe_pkg::EL_PH_UNDER]  = ph_nom_ff;
    nom_sel[vpe_pkg::EL_PH_OVER]   = ph_nom_ff;
    nom_sel[vpe_pkg::EL_NEUT_OVER] = ph_nom_ff;
    nom_sel[vpe_pkg::EL_NEG_OVER]  = ph_nom_ff;
    nom_sel[vpe_pkg::EL_AUX_UNDER] = aux_nom_ff;
    nom_sel[vpe_pkg::EL_AUX_OVER]  = aux_nom_ff;
  end

  genvar g;
  generate
    for (g = 0; g < NE; g++)
    begin : g_elem
      logic inv;
      logic below_min;

      assign thr_sc[g]  = vpe_scaled(thr_ff[g], nom_sel[g]);
      assign v_sc[g]    = vpe_vk(v_sel[g]);
      assign inv        = is_under[g] && ctl_ff[g][vpe_pkg::CTL_INV_BIT];
      // minimum voltage blocks; zero minimum never blocks
      assign below_min  = is_under[g] && (v_sel[g] < (VW+2)'(minv_ff[g]));

      // inhibit or disabled function clears the element
      // neutral element held off on delta connection
      assign clear[g] = inhibit_i[g] || !ctl_ff[g][vpe_pkg::CTL_EN_BIT]
                        || (g == vpe_pkg::EL_NEUT_OVER && delta);

      // undervoltage condition drops as soon as voltage recovers
      assign cond[g] = is_under[g] ? ((v_sc[g] < thr_sc[g]) && !below_min)
                                   : (v_sc[g] > thr_sc[g]);

      // inverse: integrate (pickup - v) up to delay * pickup
      // at zero volts this equals the delay, never faster
      assign weight[g] = inv ? AW'(thr_sc[g] - v_sc[g]) : AW'(1);
      assign target[g] = inv ? AW'(opd_ff[g]) * AW'(thr_sc[g]) : AW'(opd_ff[g]);

      vpe_timer #(
        .ACC_W (AW),
        .DLY_W (DW)
      ) u_timer (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .clear_i   (clear[g]),
        .step_i    (step_ff),
        .cond_i    (cond[g]),
        .weight_i  (weight[g]),
        .target_i  (target[g]),
        .release_i (is_under[g] ? '0 : rld_ff[g]),
        .pickup_o  (pickup_o[g]),
        .operate_o (operate_o[g])
      );
    end
  endgenerate

  // ---------------- interrupts ----------------
  logic [NE-1:0] op_prev_ff;
  logic [NE-1:0] op_rise;
  logic [NE-1:0] w1c;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      op_prev_ff <= '0;
    else
      op_prev_ff <= operate_o;
  end

  assign op_rise = operate_o & ~op_prev_ff;
  assign w1c     = (wr_go && wb_adr_i == vpe_pkg::OFS_IRQ_STAT && wb_sel_i[0])
                   ? wb_dat_i[NE-1:0] : '0;

  // a new operate edge wins over a simultaneous clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_stat_ff <= '0;
    else
      irq_stat_ff <= (irq_stat_ff & ~w1c) | op_rise;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_mask_ff <= '0;
    else if (wr_go && wb_adr_i == vpe_pkg::OFS_IRQ_MASK)
      irq_mask_ff <= NE'(vpe_merge(32'(irq_mask_ff), wb_dat_i, wb_sel_i));
  end

  assign irq_o = |(irq_stat_ff & irq_mask_ff);

  // ---------------- read path ----------------
  logic [31:0] nxt_rdat;

  always_comb
  begin
    nxt_rdat = '0;
    if (e_hit)
    begin
      case (e_reg)
        vpe_pkg::EOFS_CTRL: nxt_rdat = 32'(ctl_ff[e_idx]);
        vpe_pkg::EOFS_THR:  nxt_rdat = 32'(thr_ff[e_idx]);
        vpe_pkg::EOFS_OPD:  nxt_rdat = 32'(opd_ff[e_idx]);
        vpe_pkg::EOFS_RLD:  nxt_rdat = 32'(rld_ff[e_idx]);
        vpe_pkg::EOFS_MINV: nxt_rdat = 32'(minv_ff[e_idx]);
        default:            nxt_rdat = '0;
      endcase
    end
    else
    begin
      case (wb_adr_i)
        vpe_pkg::OFS_CONFIG:   nxt_rdat = 32'(cfg_ff);
        vpe_pkg::OFS_PH_NOM:   nxt_rdat = 32'(ph_nom_ff);
        vpe_pkg::OFS_AUX_NOM:  nxt_rdat = 32'(aux_nom_ff);
        vpe_pkg::OFS_STATE:    nxt_rdat = {16'h0, 2'h0, operate_o, 2'h0, pickup_o};
        vpe_pkg::OFS_IRQ_STAT: nxt_rdat = 32'(irq_stat_ff);
        vpe_pkg::OFS_IRQ_MASK: nxt_rdat = 32'(irq_mask_ff);
        default:               nxt_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      rdat_ff <= '0;
    else if (bus_req)
      rdat_ff <= nxt_rdat;
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule // vpe_top

/* File: vpe_meas_model.sv */
// upstream measurement stand-in: balanced three-phase magnitudes, sequence and aux channels
// assumes levels change on clk_i edges; adds one cycle of measurement latency
`timescale 1ns/1ps
module vpe_meas_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] lvl_i,
  input  wire logic [15:0] zero_i,
  input  wire logic [15:0] neg_i,
  input  wire logic [15:0] aux_i,
  output logic      [15:0] v_an_o,
  output logic      [15:0] v_bn_o,
  output logic      [15:0] v_cn_o,
  output logic      [15:0] v_ab_o,
  output logic      [15:0] v_bc_o,
  output logic      [15:0] v_ca_o,
  output logic      [15:0] v_zero_o,
  output logic      [15:0] v_neg_o,
  output logic      [15:0] v_aux_o
);
  logic [31:0] pp;
  // line voltage is root three times phase voltage, truncated
  assign pp = (32'(lvl_i) * 32'h0000_06c4) / 32'h0000_03e8;
  always_ff @(posedge clk_i)
  begin
    v_an_o   <= lvl_i;
    v_bn_o   <= lvl_i;
    v_cn_o   <= lvl_i;
    v_ab_o   <= pp[15:0];
    v_bc_o   <= pp[15:0];
    v_ca_o   <= pp[15:0];
    v_zero_o <= zero_i;
    v_neg_o  <= neg_i;
    v_aux_o  <= aux_i;
  end
endmodule // vpe_meas_model

/* File: vpe_top_assertions.sv */
// port-level checks of the voltage protection block
// assumes one clock domain clk_i with synchronous active-high rst_i
`timescale 1ns/1ps
module vpe_top_assertions #(
  parameter int unsigned STEP_CYCLES = 10
) (
  input wire logic                         clk_i,
  input wire logic                         rst_i,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic [vpe_pkg::NUM_ELEM-1:0] inhibit_i,
  input wire logic [vpe_pkg::NUM_ELEM-1:0] pickup_o,
  input wire logic [vpe_pkg::NUM_ELEM-1:0] operate_o,
  input wire logic                         irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held past one cycle");
  property p_ack_next; (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("request not answered next cycle");
  property p_ack_cause; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without a request");
  property p_dat_stands; !wb_ack_o |-> $stable(wb_dat_o); endproperty
  a_dat_stands: assert property (p_dat_stands) else $error("read data moved without ack");
  property p_inhibit_clears;
    (inhibit_i != 6'h00) |=> (((pickup_o | operate_o) & $past(inhibit_i)) == 6'h00);
  endproperty
  a_inhibit_clears: assert property (p_inhibit_clears) else $error("inhibited output high");
  property p_ph_under_instant; operate_o[0] |-> pickup_o[0]; endproperty
  a_ph_under_instant: assert property (p_ph_under_instant) else $error("phase under held");
  property p_aux_under_instant; operate_o[4] |-> pickup_o[4]; endproperty
  a_aux_under_instant: assert property (p_aux_under_instant) else $error("aux under held");
  property p_rise_needs_pickup;
    ((operate_o & ~$past(operate_o)) & ~pickup_o) == 6'h00;
  endproperty
  a_rise_needs_pickup: assert property (p_rise_needs_pickup) else $error("operate w/o pickup");

  c_ack: cover property (wb_ack_o);
  c_op_rise: cover property ($rose(operate_o[1]));
  c_inhibit: cover property (inhibit_i[0] && pickup_o[0]);
  c_irq: cover property (irq_o);
endmodule // vpe_top_assertions

bind vpe_top vpe_top_assertions #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .inhibit_i(inhibit_i),
  .pickup_o(pickup_o), .operate_o(operate_o), .irq_o(irq_o));

/* File: voltage_protection_elements_tb_top.sv */
// self-checking bench for vpe_top: threshold table, then timing and corner cases
// assumes the checker is bound in and the delay step is shortened to 10 cycles
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module voltage_protection_elements_tb_top;
  localparam int S = 10;
  typedef struct {
    logic [15:0] lvl, zero, neg, aux;
    logic [5:0]  exp;
  } vpe_row_t;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, irq;
  logic [15:0] lvl = 16'h2ee0, zero = 16'h0, neg = 16'h0, aux = 16'h2ee0;
  logic [15:0] van, vbn, vcn, vab, vbc, vca, vz, vn, vx;
  logic [5:0]  inh = 6'h00;
  logic [5:0]  pick, op;
  int          failures = 0;
  int          n_compared = 0;
  vpe_row_t    rows [4] = '{
    '{16'h2af8, 16'h0fa0, 16'h2ee0, 16'h2ee0, 6'h01},
    '{16'h2ee0, 16'h0fa1, 16'h3a99, 16'h2edf, 6'h1c},
    '{16'h30d4, 16'h0000, 16'h0000, 16'h2ee1, 6'h22},
    '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 6'h11}};

  always #5 clk_i = ~clk_i;

  vpe_meas_model meas (.clk_i(clk_i), .lvl_i(lvl), .zero_i(zero), .neg_i(neg), .aux_i(aux),
    .v_an_o(van), .v_bn_o(vbn), .v_cn_o(vcn), .v_ab_o(vab), .v_bc_o(vbc), .v_ca_o(vca),
    .v_zero_o(vz), .v_neg_o(vn), .v_aux_o(vx));
  vpe_top #(.STEP_CYCLES(S)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .v_an_i(van), .v_bn_i(vbn), .v_cn_i(vcn),
    .v_ab_i(vab), .v_bc_i(vbc), .v_ca_i(vca), .v_zero_i(vz), .v_neg_i(vn), .v_aux_i(vx),
    .inhibit_i(inh), .pickup_o(pick), .operate_o(op), .irq_o(irq));

  task tally_and_finish;
    begin
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  // request stands until the edge that samples ack high; read data is taken there
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'hf;
      n = 0;
      do
      begin
        @(posedge clk_i);
        n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1)
      begin
        failures++;
        $display("unexpected ack exp 1 got %b", ack);
        tally_and_finish;
      end
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    begin
      wb(1'b0, a, 32'h0);
      `CHK("read_data", e, q)
    end
  endtask

  task setv(input logic [15:0] l, input logic [15:0] z, input logic [15:0] n,
            input logic [15:0] x);
    begin
      @(posedge clk_i);
      lvl <= l;
      zero <= z;
      neg <= n;
      aux <= x;
    end
  endtask

  // model latency plus registered pickup
  task settle;
    repeat (3) @(negedge clk_i);
  endtask

  task wait_op(input int idx, input logic val, input int lo, input int hi);
    int n;
    begin
      n = 0;
      while (op[idx] !== val && n <= hi)
      begin
        @(negedge clk_i);
        n++;
      end
      `CHK("operate_time", 1'b1, (n >= lo && n <= hi))
      if (n > hi)
        tally_and_finish;
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h04, 32'h0000_2ee0);
    rd(8'h08, 32'h0000_2ee0);
    rd(8'h44, 32'h0000_03e8);
    rd(8'h48, 32'h0000_0064);
    rd(8'h3c, 32'h0000_0000);
    `CHK("idle_out", 13'h0000, {pick, op, irq})
    $display("reset test done");
    wb(1'b1, 8'ha4, 32'h0000_ffff);
    rd(8'ha4, 32'h0000_04e2);
    wb(1'b1, 8'he8, 32'h0000_ffff);
    rd(8'he8, 32'h0000_ea60);
    for (int i = 0; i < 6; i++)
    begin
      wb(1'b1, 8'h40 + 8'(i * 32), 32'h1);
      wb(1'b1, 8'h48 + 8'(i * 32), 32'h0);
      wb(1'b1, 8'h4c + 8'(i * 32), 32'h0);
    end
    wb(1'b1, 8'h64, 32'h0000_0708);
    foreach (rows[r])
    begin
      setv(rows[r].lvl, rows[r].zero, rows[r].neg, rows[r].aux);
      settle;
      `CHK("pickup", rows[r].exp, pick)
      `CHK("operate", rows[r].exp, op)
      rd(8'h0c, {18'h0, rows[r].exp, 2'h0, rows[r].exp});
      $display("row %0d done", r);
    end
    `CHK("irq_masked", 1'b0, irq)
    wb(1'b1, 8'h00, 32'h1);
    setv(16'h2af8, 16'h0fa1, 16'h0000, 16'h2ee0);
    settle;
    `CHK("delta_pick", 3'h0, pick[2:0])
    wb(1'b1, 8'h00, 32'h0);
    settle;
    `CHK("wye_pick", 3'h5, pick[2:0])
    wb(1'b1, 8'h00, 32'h2);
    settle;
    `CHK("pp_pick", 3'h4, pick[2:0])
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b1, 8'h50, 32'h0000_1388);
    setv(16'h0000, 16'h0000, 16'h0000, 16'h2ee0);
    settle;
    `CHK("minv_block", 1'b0, pick[0])
    setv(16'h1770, 16'h0000, 16'h0000, 16'h2ee0);
    settle;
    `CHK("minv_pass", 1'b1, pick[0])
    wb(1'b1, 8'h50, 32'h0);
    @(posedge clk_i);
    inh <= 6'h01;
    settle;
    `CHK("inhibit", 2'b00, {pick[0], op[0]})
    @(posedge clk_i);
    inh <= 6'h00;
    settle;
    `CHK("uninhibit", 1'b1, op[0])
    $display("corner test done");
    setv(16'h2ee0, 16'h0000, 16'h0000, 16'h2ee0);
    wb(1'b1, 8'h10, 32'h3f);
    wb(1'b1, 8'h14, 32'h02);
    `CHK("irq_clear", 1'b0, irq)
    wb(1'b1, 8'h68, 32'h3);
    wb(1'b1, 8'h6c, 32'h2);
    setv(16'h30d4, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(1, 1'b1, S * 3 - 1, S * 4 + 4);
    settle;
    `CHK("irq_set", 1'b1, irq)
    wb(1'b1, 8'h10, 32'h02);
    `CHK("irq_w1c", 1'b0, irq)
    setv(16'h2ee0, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(1, 1'b0, S * 2 - 1, S * 3 + 4);
    $display("definite test done");
    wb(1'b1, 8'h40, 32'h3);
    wb(1'b1, 8'h48, 32'h2);
    setv(16'h0000, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(0, 1'b1, S * 2 - 1, S * 3 + 4);
    setv(16'h2ee0, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(0, 1'b0, 0, 4);
    setv(16'h1770, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(0, 1'b1, S * 4 - 1, S * 5 + 4);
    wb(1'b1, 8'hc0, 32'h3);
    wb(1'b1, 8'hc8, 32'h2);
    setv(16'h2ee0, 16'h0000, 16'h0000, 16'h0000);
    wait_op(4, 1'b1, S * 2 - 1, S * 3 + 4);
    setv(16'h2ee0, 16'h0000, 16'h0000, 16'h2ee0);
    wait_op(4, 1'b0, 0, 4);
    $display("inverse test done");
    tally_and_finish;
  end
endmodule // voltage_protection_elements_tb_top
